/* File: core/dss_defines.svh */
// Constants of the dual synthesizer serial control block
// Function
// - Frames shift in MSB first: data field leading, four address bits last.
// - Keep only the last 21 bits shifted; never count clock pulses.
// - Clock edges ignored while enable high; frame latched on enable rising.
// - Register contents survive software or hardware power-down untouched.
// - Address 1 is the control register: loop, lock select, pump ratio.
// - Address 5 loads the principal reference ratio directly from data.
// - Address 8 loads the converter code from the low data bits.
// - Power-up presets principal main to 4500, principal reference to 65.
// - Power-up presets auxiliary main to 8000, auxiliary reference to 1040.
// - Power-up: control all ones except lock select; converter and test zero.
// - Auxiliary reference divider counts on the opposite reference edge.
// - Each phase detector pulses toward the unlock pin on phase difference.
// - Unlock pin is open drain, pulls low only, external pull-up.
// - Lock select: 00 off, aux only, principal only, or both loops.
// - Converter code 00 minimum, 7f full scale times 127/128, monotonic.
// - Loops run while their shutdown bits and power-down pins are all low.
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// ****************************************
// Frame layout
// ****************************************
`define DSS_FRAME_W 21
`define DSS_DATA_W 17
`define DSS_ADDR_W 4
`define DSS_DAC_W 7

// ****************************************
// Register addresses
// ****************************************
`define DSS_ADDR_TEST 4'h0
`define DSS_ADDR_CTRL 4'h1
`define DSS_ADDR_PMAIN 4'h4
`define DSS_ADDR_PREF 4'h5
`define DSS_ADDR_AMAIN 4'h6
`define DSS_ADDR_AREF 4'h7
`define DSS_ADDR_DAC 4'h8

// ****************************************
// Control field positions
// ****************************************
`define DSS_CTRL_LOCKP_BIT 12
`define DSS_CTRL_LOCKS_BIT 11
`define DSS_CTRL_PUMP_LSB 9
`define DSS_CTRL_PSHUT_BIT 8
`define DSS_CTRL_SSHUT_BIT 7

// ****************************************
// Power-up values
// ****************************************
`define DSS_RST_TEST 17'h00000
`define DSS_RST_CTRL 17'h1e7ff
`define DSS_RST_PMAIN 17'h01194
`define DSS_RST_PREF 17'h00041
`define DSS_RST_AMAIN 17'h01f40
`define DSS_RST_AREF 17'h00410
`define DSS_RST_DAC 7'h00

// ****************************************
// Pin sampling slots
// ****************************************
`define DSS_PIN_N 8
`define DSS_PIN_DATA 0
`define DSS_PIN_CLK 1
`define DSS_PIN_EN 2
`define DSS_PIN_REF 3
`define DSS_PIN_PRF 4
`define DSS_PIN_ARF 5
`define DSS_PIN_PPD 6
`define DSS_PIN_SPD 7
// Enable slot starts high, its idle level, so no false frame load follows reset
`define DSS_PIN_RST 8'h04

// ****************************************
// Enable gap, host side figure
// ****************************************
`define DSS_GAP_NS 4000
`define DSS_CLK_NS 10
`define DSS_GAP_CYC ((`DSS_GAP_NS + `DSS_CLK_NS - 1) / `DSS_CLK_NS)

`endif

/* File: core/dss_pkg.sv */
// Types shared by the dual synthesizer serial control block
`include "dss_defines.svh"
package dss_pkg;

    typedef struct packed {
        logic [`DSS_DATA_W-1:0] data;
        logic [`DSS_ADDR_W-1:0] addr;
    } dss_frame_s;

    typedef struct packed {
        logic [3:0] spareHigh;
        logic lockFlagPrimary;
        logic lockFlagSecondary;
        logic [1:0] pumpRatio;
        logic primaryLoopShutdown;
        logic secondaryLoopShutdown;
        logic [6:0] spareLow;
    } dss_ctrl_s;

    typedef struct packed {
        logic up;
        logic down;
    } dss_loop_s;

endpackage : dss_pkg

/* File: core/dss_ratio_divider.sv */
// Programmable ratio divider counting input ticks
`timescale 1ns/1ns
`include "dss_defines.svh"
module dss_ratio_divider (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic runEn,
    input wire logic [`DSS_DATA_W-1:0] ratio,
    output logic terminal
);

    logic [`DSS_DATA_W-1:0] count_q;
    logic [`DSS_DATA_W-1:0] count_d;
    logic terminal_q;
    logic terminal_d;

    // New ratio only takes effect at the next reload, so a frame mid-count never truncates a cycle
    always_comb begin
        count_d = count_q;
        terminal_d = 1'b0;
        if (!runEn) begin
            count_d = '0;
        end else if (tick) begin
            if (count_q == '0) begin
                terminal_d = 1'b1;
                count_d = (ratio == '0) ? '0 : `DSS_DATA_W'(ratio - `DSS_DATA_W'h1);
            end else begin
                count_d = `DSS_DATA_W'(count_q - `DSS_DATA_W'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            terminal_q <= 1'b0;
        end else begin
            count_q <= count_d;
            terminal_q <= terminal_d;
        end
    end

    assign terminal = terminal_q;

endmodule : dss_ratio_divider

/* File: core/dss_serial_ctrl.sv */
// Serial programming, register latches, dividers and unlock output of the dual synthesizer
`timescale 1ns/1ns
`include "dss_defines.svh"
module dss_serial_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic serData,
    input wire logic serClk,
    input wire logic serEnable_n,
    input wire logic referenceInput,
    input wire logic principalRfIn,
    input wire logic auxiliaryRfIn,
    input wire logic primaryPowerDown,
    input wire logic secondaryPowerDown,
    input wire logic unlockIndicatorPinIn,
    output logic unlockIndicatorPinOut,
    output logic unlockIndicatorPinOe_n,
    output logic principalPumpUp,
    output logic principalPumpDown,
    output logic auxiliaryPumpUp,
    output logic auxiliaryPumpDown,
    output logic [1:0] pumpRatio,
    output logic [`DSS_DAC_W-1:0] converterCode,
    output logic principalActive,
    output logic auxiliaryActive,
    output logic testModeActive
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic riseOf(input logic [`DSS_PIN_N-1:0] now, input logic [`DSS_PIN_N-1:0] prev,
                                    input int idx);
        riseOf = now[idx] & ~prev[idx];
    endfunction : riseOf

    // Three-state detector: both flags set means the edges met, so both clear together
    function automatic dss_pkg::dss_loop_s pfdNext(input dss_pkg::dss_loop_s cur, input logic refP,
                                                   input logic fbP, input logic run);
        dss_pkg::dss_loop_s nxt;
        nxt.up = cur.up | refP;
        nxt.down = cur.down | fbP;
        if (!run || (nxt.up && nxt.down)) begin
            nxt = '0;
        end
        pfdNext = nxt;
    endfunction : pfdNext

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [`DSS_PIN_N-1:0] pinRaw;
    logic [`DSS_PIN_N-1:0] pinSync1_q;
    logic [`DSS_PIN_N-1:0] pinSync1_d;
    logic [`DSS_PIN_N-1:0] pinSync2_q;
    logic [`DSS_PIN_N-1:0] pinSync2_d;
    logic [`DSS_PIN_N-1:0] pinSync3_q;
    logic [`DSS_PIN_N-1:0] pinSync3_d;

    assign pinRaw = {secondaryPowerDown, primaryPowerDown, auxiliaryRfIn, principalRfIn,
                     referenceInput, serEnable_n, serClk, serData};

    always_comb begin
        pinSync1_d = pinRaw;
        pinSync2_d = pinSync1_q;
        pinSync3_d = pinSync2_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSync1_q <= `DSS_PIN_RST;
            pinSync2_q <= `DSS_PIN_RST;
            pinSync3_q <= `DSS_PIN_RST;
        end else begin
            pinSync1_q <= pinSync1_d;
            pinSync2_q <= pinSync2_d;
            pinSync3_q <= pinSync3_d;
        end
    end

    // Pin rates are limited to well under half the system clock; faster inputs alias
    logic shiftTick;
    logic loadPulse;
    logic refRise;
    logic refFall;
    logic prFbTick;
    logic auxFbTick;
    logic principalRun;
    logic auxiliaryRun;

    assign shiftTick = riseOf(pinSync2_q, pinSync3_q, `DSS_PIN_CLK) & ~pinSync2_q[`DSS_PIN_EN];
    assign loadPulse = riseOf(pinSync2_q, pinSync3_q, `DSS_PIN_EN);
    assign refRise = riseOf(pinSync2_q, pinSync3_q, `DSS_PIN_REF);
    assign refFall = riseOf(pinSync3_q, pinSync2_q, `DSS_PIN_REF);
    assign prFbTick = riseOf(pinSync2_q, pinSync3_q, `DSS_PIN_PRF);
    assign auxFbTick = riseOf(pinSync2_q, pinSync3_q, `DSS_PIN_ARF);

    // ****************************************
    // Programming shift register
    // ****************************************
    logic [`DSS_FRAME_W-1:0] shift_q;
    logic [`DSS_FRAME_W-1:0] shift_d;
    dss_pkg::dss_frame_s frame;

    always_comb begin
        shift_d = shift_q;
        if (shiftTick) begin
            shift_d = {shift_q[`DSS_FRAME_W-2:0], pinSync2_q[`DSS_PIN_DATA]};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_d;
        end
    end

    assign frame = shift_q;

    // ****************************************
    // Addressed latches
    // ****************************************
    logic [`DSS_DATA_W-1:0] test_q;
    logic [`DSS_DATA_W-1:0] test_d;
    dss_pkg::dss_ctrl_s ctrl_q;
    dss_pkg::dss_ctrl_s ctrl_d;
    logic [`DSS_DATA_W-1:0] prMain_q;
    logic [`DSS_DATA_W-1:0] prMain_d;
    logic [`DSS_DATA_W-1:0] prRef_q;
    logic [`DSS_DATA_W-1:0] prRef_d;
    logic [`DSS_DATA_W-1:0] auxMain_q;
    logic [`DSS_DATA_W-1:0] auxMain_d;
    logic [`DSS_DATA_W-1:0] auxRef_q;
    logic [`DSS_DATA_W-1:0] auxRef_d;
    logic [`DSS_DAC_W-1:0] dac_q;
    logic [`DSS_DAC_W-1:0] dac_d;

    // latches change only on a frame load, never on power-down
    always_comb begin
        test_d = test_q;
        ctrl_d = ctrl_q;
        prMain_d = prMain_q;
        prRef_d = prRef_q;
        auxMain_d = auxMain_q;
        auxRef_d = auxRef_q;
        dac_d = dac_q;
        if (loadPulse) begin
            case (frame.addr)
                `DSS_ADDR_TEST: test_d = frame.data;
                `DSS_ADDR_CTRL: ctrl_d = frame.data;
                `DSS_ADDR_PMAIN: prMain_d = frame.data;
                `DSS_ADDR_PREF: prRef_d = frame.data;
                `DSS_ADDR_AMAIN: auxMain_d = frame.data;
                `DSS_ADDR_AREF: auxRef_d = frame.data;
                `DSS_ADDR_DAC: dac_d = frame.data[`DSS_DAC_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_q <= `DSS_RST_TEST;
            ctrl_q <= `DSS_RST_CTRL;
            prMain_q <= `DSS_RST_PMAIN;
            prRef_q <= `DSS_RST_PREF;
            auxMain_q <= `DSS_RST_AMAIN;
            auxRef_q <= `DSS_RST_AREF;
            dac_q <= `DSS_RST_DAC;
        end else begin
            test_q <= test_d;
            ctrl_q <= ctrl_d;
            prMain_q <= prMain_d;
            prRef_q <= prRef_d;
            auxMain_q <= auxMain_d;
            auxRef_q <= auxRef_d;
            dac_q <= dac_d;
        end
    end

    assign principalRun = ~ctrl_q.primaryLoopShutdown & ~pinSync2_q[`DSS_PIN_PPD];
    assign auxiliaryRun = ~ctrl_q.secondaryLoopShutdown & ~pinSync2_q[`DSS_PIN_SPD];

    // ****************************************
    // Dividers
    // ****************************************
    logic prRefPulse;
    logic prFbPulse;
    logic auxRefPulse;
    logic auxFbPulse;

    dss_ratio_divider uPrRef (.clk(clk), .arst_n(arst_n), .tick(refRise), .runEn(principalRun),
                              .ratio(prRef_q), .terminal(prRefPulse));
    dss_ratio_divider uPrFb (.clk(clk), .arst_n(arst_n), .tick(prFbTick), .runEn(principalRun),
                             .ratio(prMain_q), .terminal(prFbPulse));
    dss_ratio_divider uAuxRef (.clk(clk), .arst_n(arst_n), .tick(refFall), .runEn(auxiliaryRun),
                               .ratio(auxRef_q), .terminal(auxRefPulse));
    dss_ratio_divider uAuxFb (.clk(clk), .arst_n(arst_n), .tick(auxFbTick), .runEn(auxiliaryRun),
                              .ratio(auxMain_q), .terminal(auxFbPulse));

    // ****************************************
    // Phase detectors and outputs
    // ****************************************
    dss_pkg::dss_loop_s pdPrin_q;
    dss_pkg::dss_loop_s pdPrin_d;
    dss_pkg::dss_loop_s pdAux_q;
    dss_pkg::dss_loop_s pdAux_d;
    logic unlockOe_n_q;
    logic unlockOe_n_d;
    logic unlockOut_q;
    logic unlockOut_d;
    logic prinActive_q;
    logic prinActive_d;
    logic auxActive_q;
    logic auxActive_d;
    logic testActive_q;
    logic testActive_d;

    always_comb begin
        pdPrin_d = pfdNext(pdPrin_q, prRefPulse, prFbPulse, principalRun);
        pdAux_d = pfdNext(pdAux_q, auxRefPulse, auxFbPulse, auxiliaryRun);
        unlockOe_n_d = ~((ctrl_q.lockFlagPrimary & (pdPrin_q.up | pdPrin_q.down)) |
                         (ctrl_q.lockFlagSecondary & (pdAux_q.up | pdAux_q.down)));
        unlockOut_d = 1'b0;
        prinActive_d = principalRun;
        auxActive_d = auxiliaryRun;
        testActive_d = |test_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pdPrin_q <= '0;
            pdAux_q <= '0;
            unlockOe_n_q <= 1'b1;
            unlockOut_q <= 1'b0;
            prinActive_q <= 1'b0;
            auxActive_q <= 1'b0;
            testActive_q <= 1'b0;
        end else begin
            pdPrin_q <= pdPrin_d;
            pdAux_q <= pdAux_d;
            unlockOe_n_q <= unlockOe_n_d;
            unlockOut_q <= unlockOut_d;
            prinActive_q <= prinActive_d;
            auxActive_q <= auxActive_d;
            testActive_q <= testActive_d;
        end
    end

    assign unlockIndicatorPinOut = unlockOut_q;
    assign unlockIndicatorPinOe_n = unlockOe_n_q;
    assign principalPumpUp = pdPrin_q.up;
    assign principalPumpDown = pdPrin_q.down;
    assign auxiliaryPumpUp = pdAux_q.up;
    assign auxiliaryPumpDown = pdAux_q.down;
    assign pumpRatio = ctrl_q.pumpRatio;
    // code passed straight to the monotonic converter
    assign converterCode = dac_q;
    assign principalActive = prinActive_q;
    assign auxiliaryActive = auxActive_q;
    assign testModeActive = testActive_q;

    // ****************************************
    // Checks
    // ****************************************
    chk_shift_msb: assert property (@(posedge clk) disable iff (!arst_n)
        shiftTick |=> shift_q[0] == $past(pinSync2_q[`DSS_PIN_DATA]) && shift_q[20:1] == $past(shift_q[19:0]))
        else $error("Shift register did not take the new bit at the low end");
    chk_ignore_clk: assert property (@(posedge clk) disable iff (!arst_n)
        pinSync2_q[`DSS_PIN_EN] |=> $stable(shift_q))
        else $error("Shift register moved while enable high");
    chk_ctrl_load: assert property (@(posedge clk) disable iff (!arst_n)
        loadPulse && frame.addr == `DSS_ADDR_CTRL |=> ctrl_q == $past(frame.data))
        else $error("Control latch not loaded from frame");
    chk_pref_load: assert property (@(posedge clk) disable iff (!arst_n)
        loadPulse && frame.addr == `DSS_ADDR_PREF |=> prRef_q == $past(frame.data))
        else $error("Principal reference latch not loaded");
    chk_dac_load: assert property (@(posedge clk) disable iff (!arst_n)
        loadPulse && frame.addr == `DSS_ADDR_DAC |=> converterCode == $past(frame.data[`DSS_DAC_W-1:0]))
        else $error("Converter code not loaded");
    chk_amain_load: assert property (@(posedge clk) disable iff (!arst_n)
        loadPulse && frame.addr == `DSS_ADDR_AMAIN |=> auxMain_q == $past(frame.data) && $stable(prMain_q))
        else $error("Auxiliary main latch decode wrong");
    chk_latch_retain: assert property (@(posedge clk) disable iff (!arst_n)
        !loadPulse |=> $stable(prMain_q) && $stable(auxRef_q) && $stable(ctrl_q))
        else $error("Latch changed without a frame load");
    chk_aux_edge: assert property (@(posedge clk) disable iff (!arst_n)
        !(prRefPulse && auxRefPulse))
        else $error("Both reference dividers fired in one cycle");
    chk_unlock_src: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl_q.lockFlagPrimary && pdPrin_q.up |=> !unlockIndicatorPinOe_n)
        else $error("Principal phase error did not pull unlock pin");
    chk_unlock_off: assert property (@(posedge clk) disable iff (!arst_n)
        !ctrl_q.lockFlagPrimary && !ctrl_q.lockFlagSecondary |=> unlockIndicatorPinOe_n)
        else $error("Unlock pin driven while disabled");
    chk_od_low: assert property (@(posedge clk) disable iff (!arst_n)
        !unlockIndicatorPinOe_n |-> !unlockIndicatorPinOut)
        else $error("Unlock pin driven high");
    chk_loop_run: assert property (@(posedge clk) disable iff (!arst_n)
        !ctrl_q.primaryLoopShutdown && !pinSync2_q[`DSS_PIN_PPD] |=> principalActive)
        else $error("Principal loop not running with shutdown clear");

    cov_frame_load: cover property (@(posedge clk) disable iff (!arst_n) loadPulse && frame.addr == `DSS_ADDR_PMAIN);
    cov_unlock_pull: cover property (@(posedge clk) disable iff (!arst_n) $fell(unlockIndicatorPinOe_n));
    cov_aux_pulse: cover property (@(posedge clk) disable iff (!arst_n) auxRefPulse);

endmodule : dss_serial_ctrl

/* File: tb/dss_host_model.sv */
// Host model that drives the three-wire programming bus
`timescale 1ns/1ns
`include "dss_defines.svh"
module dss_host_model (
    input wire logic clk,
    output logic serData,
    output logic serClk,
    output logic serEnable_n
);
    initial begin
        serData = 1'b0;
        serClk = 1'b0;
        serEnable_n = 1'b1;
    end

    // Each level stands two cycles so the three-stage pin sync always sees it
    task automatic hold;
        repeat (2) @(negedge clk);
    endtask : hold

    task automatic pulse(input logic b);
        serData <= b;
        hold();
        serClk <= 1'b1;
        hold();
        serClk <= 1'b0;
    endtask : pulse

    // msb first, inside an enable-low burst
    task automatic send(input logic [31:0] bits, input int n);
        serEnable_n <= 1'b0;
        hold();
        for (int i = n - 1; i >= 0; i--) begin
            pulse(bits[i]);
        end
        hold();
        serEnable_n <= 1'b1;
        // Released data line shows the inverse so a stale level cannot pass
        serData <= ~bits[0];
        // full gap; the short gap would need fast divider inputs not modelled
        repeat (`DSS_GAP_CYC) @(negedge clk);
    endtask : send

    // clock pulse with enable high, which the device must ignore
    task automatic stray_clock(input logic b);
        pulse(b);
        hold();
        serData <= ~b;
    endtask : stray_clock
endmodule : dss_host_model

/* File: tb/dss_serial_ctrl_tb.sv */
// Self-checking testbench of the dual synthesizer serial control block
`timescale 1ns/1ns
`include "dss_defines.svh"
module dss_serial_ctrl_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic serData, serClk, serEnable_n;
    logic referenceInput = 1'b0;
    logic principalRfIn = 1'b0;
    logic auxiliaryRfIn = 1'b0;
    logic primaryPowerDown = 1'b0;
    logic secondaryPowerDown = 1'b0;
    logic lockWire, pinOut, pinOe_n, pUp, pDn, aUp, aDn;
    logic principalActive, auxiliaryActive, testModeActive;
    logic [1:0] pumpRatio;
    logic [`DSS_DAC_W-1:0] converterCode;
    int num_errors = 0;
    int checks = 0;
    int pulls;
    logic [16:0] selCtrl [6] = '{17'h01a00, 17'h00400, 17'h00e80, 17'h01300, 17'h00a00, 17'h01000};
    logic selPull [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    always #5 clk = ~clk;

    // Pull-up on the open-drain unlock wire
    assign lockWire = pinOe_n ? 1'b1 : pinOut;

    dss_host_model host (.clk(clk), .serData(serData), .serClk(serClk), .serEnable_n(serEnable_n));

    dss_serial_ctrl uut (
        .clk(clk), .arst_n(arst_n), .serData(serData), .serClk(serClk), .serEnable_n(serEnable_n),
        .referenceInput(referenceInput), .principalRfIn(principalRfIn), .auxiliaryRfIn(auxiliaryRfIn),
        .primaryPowerDown(primaryPowerDown), .secondaryPowerDown(secondaryPowerDown),
        .unlockIndicatorPinIn(lockWire), .unlockIndicatorPinOut(pinOut), .unlockIndicatorPinOe_n(pinOe_n),
        .principalPumpUp(pUp), .principalPumpDown(pDn), .auxiliaryPumpUp(aUp), .auxiliaryPumpDown(aDn),
        .pumpRatio(pumpRatio), .converterCode(converterCode), .principalActive(principalActive),
        .auxiliaryActive(auxiliaryActive), .testModeActive(testModeActive)
    );

    // ****************************************
    // Compare and report
    // ****************************************
    task automatic check_vec(input string what, input logic [16:0] exp, input logic [16:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic summarize;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    function automatic logic [31:0] frm(input logic [16:0] d, input logic [3:0] a);
        return {11'h000, d, a};
    endfunction : frm

    // Reference runs only in observe windows; low cycles of the wire are counted
    task automatic run_ref(output int lows);
        lows = 0;
        for (int i = 0; i < 120; i++) begin
            @(negedge clk);
            referenceInput = (i % 8) < 4;
            if (lockWire !== 1'b1) begin
                lows++;
            end
        end
        referenceInput = 1'b0;
    endtask : run_ref

    initial begin
        #900000;
        num_errors++;
        summarize();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check_vec("pumpRatio", 17'h00003, {15'h0000, pumpRatio});
        check_vec("converterCode", 17'h00000, {10'h000, converterCode});
        check_bit("testModeActive", 1'b0, testModeActive);
        check_bit("principalActive", 1'b0, principalActive);
        check_bit("lockWire", 1'b1, lockWire);
        // Four extra leading ones must fall off the front of the frame
        host.send({7'h00, 4'hf, 17'h0007b, 4'h8}, 25);
        check_vec("converterCode", 17'h0007b, {10'h000, converterCode});
        // Only four new bits: the old frame moves up by four, not five
        host.stray_clock(1'b1);
        host.send(32'h00000008, 4);
        check_vec("converterCode", 17'h00038, {10'h000, converterCode});
        host.send(frm(17'h0007f, 4'h9), 21);
        check_vec("converterCode", 17'h00038, {10'h000, converterCode});
        host.send(frm(17'h00001, 4'h0), 21);
        check_bit("testModeActive", 1'b1, testModeActive);
        host.send(frm(17'h00000, 4'h0), 21);
        check_bit("testModeActive", 1'b0, testModeActive);
        for (int a = 4; a < 8; a++) begin
            host.send(frm(17'h00002, a[3:0]), 21);
        end
        for (int k = 0; k < 6; k++) begin
            host.send(frm(selCtrl[k], 4'h1), 21);
            check_vec("pumpRatio", {15'h0000, selCtrl[k][10:9]}, {15'h0000, pumpRatio});
            check_bit("auxiliaryActive", ~selCtrl[k][7], auxiliaryActive);
            run_ref(pulls);
            check_bit("unlockPull", selPull[k], pulls != 0);
        end
        primaryPowerDown = 1'b1;
        repeat (6) @(negedge clk);
        check_bit("principalActive", 1'b0, principalActive);
        primaryPowerDown = 1'b0;
        repeat (6) @(negedge clk);
        check_bit("principalActive", 1'b1, principalActive);
        check_vec("pumpRatio", 17'h00000, {15'h0000, pumpRatio});
        run_ref(pulls);
        check_bit("unlockPull", 1'b1, pulls != 0);
        check_bit("principalPumpUp", 1'b1, pUp);
        check_bit("principalPumpDown", 1'b0, pDn);
        check_bit("auxiliaryPumpUp", 1'b1, aUp);
        check_bit("auxiliaryPumpDown", 1'b0, aDn);
        // One feedback edge meets the pending reference edge and clears the detector
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            principalRfIn = i < 4;
        end
        repeat (6) @(negedge clk);
        check_bit("principalPumpUp", 1'b0, pUp);
        check_bit("principalPumpDown", 1'b0, pDn);
        check_bit("lockWire", 1'b1, lockWire);
        summarize();
    end
endmodule : dss_serial_ctrl_tb
